// ### sim/rdt_far_side.sv
// Far-side model: prescaler tick source and external pin driver.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module rdt_far_side
  import rdt_pkg::*;
(
  input  wire logic          aclk,  // Machine clock
  output logic [PRESC_N-1:0] tick,  // Prescaler pulses
  output logic               pin    // External input pin
);
  initial begin
    tick = '0;
    pin  = 1'b0;
  end

  // One-cycle pulse on a single prescaler output
  task automatic pulse(input int idx);
    @(posedge aclk);
    tick <= PRESC_N'(1) << idx;
    @(posedge aclk);
    tick <= '0;
  endtask : pulse

  // Slow pin change; held past the synchroniser delay
  task automatic drive(input logic v);
    @(posedge aclk);
    pin <= v;
    repeat (8) @(posedge aclk);
  endtask : drive
endmodule : rdt_far_side

// ### sim/rdt_timer_bench.sv
// Self-checking bench for the reload down timer over AXI4-Lite.
// Assumes the far-side model supplies ticks and pin edges on request.
`timescale 1ns/1ps
module rdt_timer_bench
  import rdt_pkg::*;
;
  logic              aclk;
  logic              aresetn;
  logic [PRESC_N-1:0] tick;
  logic              pin;
  logic              wave;
  logic              wsel;
  logic              irq;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic [31:0]       s_axi_wdata;
  logic [31:0]       s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  int                err_total;
  int                checks;

  rdt_timer uut (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .presc_tick      (tick),
    .ext_input_pin   (pin),
    .wave_output_pin (wave),
    .wave_output_sel (wsel),
    .underflow_irq   (irq),
    .s_axi_awaddr    (s_axi_awaddr),
    .s_axi_awvalid   (s_axi_awvalid),
    .s_axi_awready   (s_axi_awready),
    .s_axi_wdata     (s_axi_wdata),
    .s_axi_wstrb     (s_axi_wstrb),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .s_axi_bresp     (s_axi_bresp),
    .s_axi_bvalid    (s_axi_bvalid),
    .s_axi_bready    (s_axi_bready),
    .s_axi_araddr    (s_axi_araddr),
    .s_axi_arvalid   (s_axi_arvalid),
    .s_axi_arready   (s_axi_arready),
    .s_axi_rdata     (s_axi_rdata),
    .s_axi_rresp     (s_axi_rresp),
    .s_axi_rvalid    (s_axi_rvalid),
    .s_axi_rready    (s_axi_rready)
  );

  rdt_far_side far (.aclk(aclk), .tick(tick), .pin(pin));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic hang;
    err_total++;
    complete_run();
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OK);
    int         n;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) hang();
    else chk("bresp", 32'(er), 32'(r));
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er = RESP_OK);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) hang();
    else begin
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
    end
  endtask : rdc

  // Let registered pin outputs land before looking at them
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  initial begin
    err_total     = 0;
    checks        = 0;
    aresetn       = 1'b0;
    s_axi_awaddr  = '0;
    s_axi_araddr  = '0;
    s_axi_wdata   = '0;
    s_axi_wstrb   = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0);
    rdc(8'h18, 32'h0, RESP_ERR);
    wr(8'h1c, 32'hff, RESP_ERR);
    wr(A_CNT_LO, 32'h55);
    rdc(A_CNT_LO, 32'h0);
    // Reload mode, soft start, clock select one
    wr(A_CSR_HI, 32'h08);
    wr(A_RLD_LO, 32'h02);
    wr(A_CSR_LO, 32'h53);
    rdc(A_CNT_LO, 32'h02);
    far.pulse(0);
    rdc(A_CNT_LO, 32'h02);
    far.pulse(1);
    rdc(A_CNT_LO, 32'h01);
    far.pulse(1);
    far.pulse(1);
    rdc(A_CNT_LO, 32'h02);
    rdc(A_CSR_LO, 32'h56);
    settle();
    chk("wave", 32'h1, 32'(wave));
    chk("wsel", 32'h1, 32'(wsel));
    chk("irq", 32'h0, 32'(irq));
    wr(A_CSR_LO, 32'h5e);
    settle();
    chk("irq", 32'h1, 32'(irq));
    wr(A_CSR_LO, 32'h5a);
    settle();
    chk("irq", 32'h0, 32'(irq));
    rdc(A_CSR_LO, 32'h5a);
    for (int i = 0; i < 3; i++) far.pulse(1);
    settle();
    chk("irq", 32'h1, 32'(irq));
    chk("wave", 32'h0, 32'(wave));
    rdc(A_CSR_LO, 32'h5e);
    // One-shot run
    wr(A_CSR_LO, 32'h00);
    wr(A_RLD_LO, 32'h01);
    wr(A_CSR_LO, 32'h43);
    settle();
    chk("wave", 32'h1, 32'(wave));
    far.pulse(1);
    far.pulse(1);
    far.pulse(1);
    rdc(A_CNT_LO, 32'hff);
    rdc(A_CNT_HI, 32'hff);
    rdc(A_CSR_LO, 32'h46);
    settle();
    chk("wave", 32'h0, 32'(wave));
    // Edge triggers: rising, falling, both
    for (int m = 1; m < 4; m++) begin
      wr(A_CSR_LO, 32'h00);
      wr(A_CSR_HI, 32'(8 + m));
      wr(A_RLD_LO, 32'(16 + m));
      wr(A_CSR_LO, 32'h02);
      far.drive(1'b1);
      rdc(A_CNT_LO, (m == 2) ? 32'h11 : 32'(16 + m));
      far.drive(1'b0);
      rdc(A_CNT_LO, 32'(16 + m));
    end
    wr(A_CSR_LO, 32'h00);
    wr(A_RLD_LO, 32'h05);
    wr(A_CSR_LO, 32'h03);
    rdc(A_CNT_LO, 32'h05);
    wr(A_CSR_HI, 32'h08);
    wr(A_RLD_LO, 32'h09);
    far.drive(1'b1);
    rdc(A_CNT_LO, 32'h05);
    // Gate low active, then high active
    wr(A_RLD_LO, 32'h03);
    for (int g = 4; g < 6; g++) begin
      wr(A_CSR_LO, 32'h00);
      wr(A_CSR_HI, 32'(8 + g));
      far.drive(~g[0]);
      wr(A_CSR_LO, 32'h03);
      far.pulse(1);
      rdc(A_CNT_LO, 32'h03);
      far.drive(g[0]);
      far.pulse(1);
      rdc(A_CNT_LO, 32'h02);
    end
    // Event count on rising pin edges
    wr(A_CSR_LO, 32'h00);
    wr(A_CSR_HI, 32'h39);
    wr(A_RLD_LO, 32'h02);
    far.drive(1'b0);
    wr(A_CSR_LO, 32'h03);
    rdc(A_CNT_LO, 32'h02);
    far.pulse(1);
    far.pulse(0);
    rdc(A_CNT_LO, 32'h02);
    far.drive(1'b1);
    rdc(A_CNT_LO, 32'h01);
    far.drive(1'b0);
    rdc(A_CNT_LO, 32'h01);
    far.drive(1'b1);
    rdc(A_CNT_LO, 32'h00);
    // Low byte lane off: write is dropped but still answered OKAY
    s_axi_wstrb <= 4'h0;
    wr(A_RLD_LO, 32'h77);
    s_axi_wstrb <= 4'hf;
    rdc(A_RLD_LO, 32'h02);
    complete_run();
  end
endmodule : rdt_timer_bench

// ### verilog/rdt_pin_sync.sv
// Synchroniser and edge detector for the timer's external input pin.
// Assumes the pin is asynchronous to aclk; adds four cycles of latency.
`timescale 1ns/1ps
module rdt_pin_sync
  import rdt_pkg::*;
(
  input  wire logic  aclk,     // Machine clock
  input  wire logic  aresetn,  // Synchronous reset, active low
  input  wire logic  pin_in,   // Raw external pin level
  output rdt_pin_ev_t ev       // Filtered level and edge pulses
);

  rdt_sync_st_t s_r;
  rdt_sync_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.sync = {s_r.sync[1:0], pin_in};
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    // Stage one feeds only stage two; decisions use the later pair
    if (s_r.sync[1] == s_r.sync[2] && s_r.sync[2] != s_r.level) begin
      s_nxt.level = s_r.sync[2];
      s_nxt.rise  = s_r.sync[2];
      s_nxt.fall  = ~s_r.sync[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ev = '{level: s_r.level, rise: s_r.rise, fall: s_r.fall};

endmodule : rdt_pin_sync

// ### verilog/rdt_pkg.sv
// Package for the 16-bit reload down timer: register map, field layout,
// codes, and the types shared by the timer core and its pin synchroniser.
// Assumes a 32-bit AXI4-Lite master and a single 20 MHz clock domain.
package rdt_pkg;

  localparam int          CNT_W     = 16;
  localparam int          ADDR_W    = 8;
  localparam int          PRESC_N   = 7;

  // Register byte addresses, one aligned word each
  localparam logic [7:0]  A_CSR_LO  = 8'h00;
  localparam logic [7:0]  A_CSR_HI  = 8'h04;
  localparam logic [7:0]  A_RLD_LO  = 8'h08;
  localparam logic [7:0]  A_RLD_HI  = 8'h0c;
  localparam logic [7:0]  A_CNT_LO  = 8'h10;
  localparam logic [7:0]  A_CNT_HI  = 8'h14;

  // control_status_low bit positions
  localparam int          B_TRG     = 0;
  localparam int          B_COUNT_ENABLE    = 1;
  localparam int          B_UF      = 2;
  localparam int          B_UNDERFLOW_IRQ_ENABLE    = 3;
  localparam int          B_RELOAD_SELECT    = 4;
  localparam int          B_OUTPUT_LEVEL    = 5;
  localparam int          B_OUTPUT_ENABLE    = 6;

  // control_status_high field positions
  localparam int          F_MOD_LSB = 0;
  localparam int          F_CSL_LSB = 3;
  localparam int          B_GATE    = 2;
  localparam int          B_GATE_HI = 0;
  localparam int          B_RISE    = 0;
  localparam int          B_FALL    = 1;

  localparam logic [2:0]  CSL_EVENT = 3'h7;
  localparam logic [15:0] CNT_ALL1  = 16'hffff;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {PH_STOP, PH_WAIT, PH_RUN} rdt_phase_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } rdt_pin_ev_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       rise;
    logic       fall;
  } rdt_sync_st_t;

  typedef struct packed {
    rdt_phase_t  phase;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [2:0]  csl;
    logic [2:0]  mod;
    logic        output_enable;
    logic        output_level;
    logic        reload_select;
    logic        underflow_irq_enable;
    logic        uf;
    logic        count_enable;
    logic        tog;
    logic        irq;
    logic        wave;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
    logic        wlane;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rdt_state_t;

  localparam rdt_state_t ST_RESET = '0;

endpackage : rdt_pkg

// ### verilog/rdt_timer.sv
// One channel of a 16-bit reload down timer with an AXI4-Lite register
// slave. Assumes prescaled tick pulses arrive from same-clock logic.
// Behaviour
// - Wrap from zero sets the underflow flag
// - Flag and enable together raise the interrupt
// - Enabling with flag already set fires immediately
// - Three phases: halted, waiting, running
// - Internal mode decrements per selected prescaler tick
// - Start loads reload value and begins counting
// - Enable plus trigger in one write starts
// - Reload mode reloads on underflow and continues
// - Reload mode output toggles at each underflow
// - Selected pin edge starts counter when enabled
// - Software trigger also starts in edge mode
// - Gate mode counts only at active pin level
// - One-shot underflow stops counter at all ones
// - One-shot output marks the running interval
// - Event mode decrements on selected pin edges
// - Event mode arms on enable plus trigger
// - Writing zero to flag clears it
// - Clock select seven means event count mode
// - Trigger config decodes soft, edges, gate level
// - Output enable hands the pin to the timer
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rdt_timer
  import rdt_pkg::*;
#(
  parameter int TIMER_W = CNT_W  // Counter width
)(
  input  wire logic               aclk,          // 20 MHz machine clock
  input  wire logic               aresetn,       // Synchronous reset
  input  wire logic [PRESC_N-1:0] presc_tick,    // Prescaler pulses
  input  wire logic               ext_input_pin, // Trigger/gate/event
  output logic                    wave_output_pin, // Timer waveform
  output logic                    wave_output_sel, // Timer owns pin
  output logic                    underflow_irq,   // Interrupt request
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,  // Write address
  input  wire logic               s_axi_awvalid, // Write addr valid
  output logic                    s_axi_awready, // Write addr ready
  input  wire logic [31:0]        s_axi_wdata,   // Write data
  input  wire logic [3:0]         s_axi_wstrb,   // Byte enables
  input  wire logic               s_axi_wvalid,  // Write data valid
  output logic                    s_axi_wready,  // Write data ready
  output logic [1:0]              s_axi_bresp,   // Write response
  output logic                    s_axi_bvalid,  // Response valid
  input  wire logic               s_axi_bready,  // Response ready
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,  // Read address
  input  wire logic               s_axi_arvalid, // Read addr valid
  output logic                    s_axi_arready, // Read addr ready
  output logic [31:0]             s_axi_rdata,   // Read data
  output logic [1:0]              s_axi_rresp,   // Read response
  output logic                    s_axi_rvalid,  // Read data valid
  input  wire logic               s_axi_rready   // Read data ready
);

  if (TIMER_W != CNT_W) begin : g_bad_width
    $error("rdt_timer: only a 16-bit counter is supported");
  end

  rdt_state_t  s_r;
  rdt_state_t  s_nxt;
  rdt_pin_ev_t pin_ev;

  // Bus and timer events exposed for the checks below
  logic        wr_do;
  logic        wr_lo;
  logic        start;
  logic        tick;
  logic        gate_ok;
  logic        uf_set;

  rdt_pin_sync u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (ext_input_pin),
    .ev      (pin_ev)
  );

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == A_CSR_LO) || (a == A_CSR_HI) ||
                (a == A_RLD_LO) || (a == A_RLD_HI) ||
                (a == A_CNT_LO) || (a == A_CNT_HI);
  endfunction : is_mapped

  // Prohibited gate codes in event mode simply never see an edge
  function automatic logic edge_hit(input logic [2:0] m,
                                    input rdt_pin_ev_t e);
    edge_hit = ~m[B_GATE] &
               ((m[B_RISE] & e.rise) | (m[B_FALL] & e.fall));
  endfunction : edge_hit

  function automatic logic [31:0] read_word(input rdt_state_t st,
                                            input logic [7:0] a);
    read_word = '0;
    unique case (a)
      A_CSR_LO: read_word[7:0] = {1'b0, st.output_enable, st.output_level, st.reload_select,
                                  st.underflow_irq_enable, st.uf, st.count_enable,
                                  1'b0};
      A_CSR_HI: read_word[7:0] = {2'h0, st.csl, st.mod};
      A_RLD_LO: read_word[7:0] = st.rld[7:0];
      A_RLD_HI: read_word[7:0] = st.rld[15:8];
      A_CNT_LO: read_word[7:0] = st.cnt[7:0];
      A_CNT_HI: read_word[7:0] = st.cnt[15:8];
      default:  read_word = '0;
    endcase
  endfunction : read_word

  always_comb begin
    logic event_mode;
    event_mode = 1'b0;
    s_nxt      = s_r;
    wr_do      = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
    wr_lo      = wr_do & s_r.wlane & (s_r.waddr == A_CSR_LO);

    // Write channel: address and data taken independently
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.wlane = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = is_mapped(s_r.waddr) ? RESP_OK : RESP_ERR;
      if (s_r.wlane) begin
        unique case (s_r.waddr)
          A_CSR_LO: begin
            s_nxt.output_enable = s_r.wdata[B_OUTPUT_ENABLE];
            s_nxt.output_level = s_r.wdata[B_OUTPUT_LEVEL];
            s_nxt.reload_select = s_r.wdata[B_RELOAD_SELECT];
            s_nxt.underflow_irq_enable = s_r.wdata[B_UNDERFLOW_IRQ_ENABLE];
            s_nxt.count_enable = s_r.wdata[B_COUNT_ENABLE];
            if (!s_r.wdata[B_UF]) begin
              s_nxt.uf = 1'b0;
            end
          end
          A_CSR_HI: begin
            s_nxt.csl = s_r.wdata[F_CSL_LSB +: 3];
            s_nxt.mod = s_r.wdata[F_MOD_LSB +: 3];
          end
          A_RLD_LO: s_nxt.rld[7:0]  = s_r.wdata;
          A_RLD_HI: s_nxt.rld[15:8] = s_r.wdata;
          default:  s_nxt.bresp = s_nxt.bresp;
        endcase
      end
    end
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_got & ~s_nxt.bvalid;

    // Read channel: one read outstanding, answered one edge later
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = read_word(s_r, s_axi_araddr);
      s_nxt.rresp  = is_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
    end
    s_nxt.arready = ~s_nxt.rvalid;

    // Count source and gate, from the updated configuration
    event_mode = (s_nxt.csl == CSL_EVENT);
    tick       = event_mode ? edge_hit(s_nxt.mod, pin_ev)
                            : presc_tick[s_nxt.csl];
    gate_ok    = event_mode || !s_nxt.mod[B_GATE] ||
                 (pin_ev.level == s_nxt.mod[B_GATE_HI]);

    // Trigger bit is a strobe only; a zero write does nothing
    start = s_nxt.count_enable &
            ((wr_lo & s_r.wdata[B_TRG]) |
             (~event_mode & edge_hit(s_nxt.mod, pin_ev)));

    uf_set = 1'b0;
    if (!s_nxt.count_enable) begin
      s_nxt.phase = PH_STOP;
    end else if (start) begin
      s_nxt.phase = PH_RUN;
      s_nxt.cnt   = s_nxt.rld;
      s_nxt.tog   = 1'b0;
    end else if (s_r.phase == PH_STOP) begin
      s_nxt.phase = PH_WAIT;
    end else if (s_r.phase == PH_RUN && tick && gate_ok) begin
      if (s_r.cnt == CNT_ZERO) begin
        uf_set = 1'b1;
        if (s_nxt.reload_select) begin
          s_nxt.cnt = s_nxt.rld;
          s_nxt.tog = ~s_r.tog;
        end else begin
          s_nxt.cnt   = CNT_ALL1;
          s_nxt.phase = PH_WAIT;
        end
      end else begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end

    // A new underflow beats a clearing write in the same cycle
    s_nxt.uf   = s_nxt.uf | uf_set;
    s_nxt.irq  = s_nxt.uf & s_nxt.underflow_irq_enable;
    s_nxt.wave = s_nxt.output_level ^ (s_nxt.reload_select ? s_nxt.tog
                                          : (s_nxt.phase == PH_RUN));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin override is just the enable bit; port direction lives elsewhere
  assign wave_output_pin = s_r.wave;
  assign wave_output_sel = s_r.output_enable;
  assign underflow_irq   = s_r.irq;
  assign s_axi_awready   = s_r.awready;
  assign s_axi_wready    = s_r.wready;
  assign s_axi_bvalid    = s_r.bvalid;
  assign s_axi_bresp     = s_r.bresp;
  assign s_axi_arready   = s_r.arready;
  assign s_axi_rvalid    = s_r.rvalid;
  assign s_axi_rdata     = s_r.rdata;
  assign s_axi_rresp     = s_r.rresp;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  uf_flag_a: assert property (uf_set |=> s_r.uf)
    else $error("underflow did not set the flag");

  irq_match_a: assert property (
    s_r.irq == (s_r.uf && s_r.underflow_irq_enable))
    else $error("interrupt does not follow flag and enable");

  irq_late_a: assert property (
    ($rose(s_r.underflow_irq_enable) && s_r.uf) |-> underflow_irq)
    else $error("late enable did not raise interrupt");

  halt_phase_a: assert property (
    !s_r.count_enable |-> s_r.phase == PH_STOP)
    else $error("counter not halted while disabled");

  start_load_a: assert property (
    start |=> (s_r.phase == PH_RUN) &&
              (s_r.cnt == $past(s_nxt.rld)))
    else $error("start did not load the reload value");

  reload_cont_a: assert property (
    (uf_set && s_nxt.reload_select) |=> (s_r.phase == PH_RUN) &&
      (s_r.cnt == $past(s_nxt.rld)) && (s_r.tog != $past(s_r.tog)))
    else $error("reload underflow did not reload and toggle");

  oneshot_stop_a: assert property (
    (uf_set && !s_nxt.reload_select) |=>
      (s_r.cnt == CNT_ALL1) && (s_r.phase == PH_WAIT))
    else $error("one-shot underflow did not stop at all ones");

  gate_hold_a: assert property (
    (s_r.phase == PH_RUN && !gate_ok && !start && s_r.count_enable &&
     s_nxt.count_enable) |=> s_r.cnt == $past(s_r.cnt))
    else $error("counter moved with gate inactive");

  uf_clear_a: assert property (
    (wr_lo && !s_r.wdata[B_UF] && !uf_set) |=> !s_r.uf)
    else $error("writing zero did not clear the flag");

  oneshot_wave_a: assert property (
    (!s_r.reload_select && s_r.phase == PH_RUN) |->
      wave_output_pin == ~s_r.output_level)
    else $error("one-shot waveform wrong while running");

  cov_reload_uf: cover property (uf_set && s_nxt.reload_select);
  cov_oneshot_uf: cover property (uf_set && !s_nxt.reload_select);
  cov_edge_start: cover property (start && !wr_lo);
  cov_gate_pause: cover property (s_r.phase == PH_RUN && !gate_ok);

endmodule : rdt_timer
